/* File: core/mdgs_map.vh */
/*
  Constants for the motion data group sequencer: field codes, group
  table layout, value limits and mode codes.
  Assumes inclusion by bare name from the core design files and the sim checker.
*/
`ifndef MDGS_MAP_VH
`define MDGS_MAP_VH

// ==========================================================
// Table layout
`define MDGS_GROUPS          32
`define MDGS_GRP_W           5
`define MDGS_PARAM_GROUPS    5'h0_F
`define MDGS_PNUM_W          8
`define MDGS_PNUM_STRIDE_LSB 3
`define MDGS_DATA_W          16

// ==========================================================
// Entry codes within one block of eight
`define MDGS_FLD_TYPE        3'h0
`define MDGS_FLD_POS_LO      3'h1
`define MDGS_FLD_POS_HI      3'h2
`define MDGS_FLD_SPEED       3'h3
`define MDGS_FLD_NEXT        3'h7

// ==========================================================
// Group type codes
`define MDGS_TYPE_INVALID    2'h0
`define MDGS_TYPE_ABS        2'h1
`define MDGS_TYPE_REL        2'h2

// ==========================================================
// Value limits and scaling
`define MDGS_POS_MAX         16'sh2_70F
`define MDGS_POS_MIN         (-16'sh2_70F)
`define MDGS_POS_HI_SCALE    32'sh0000_2710
`define MDGS_SPEED_MAX       16'h1_770
`define MDGS_SPEED_W         13
`define MDGS_POS_W           32

// ==========================================================
// Mode codes
`define MDGS_CTRL_MODE_SEQ   4'hC
`define MDGS_START_SINGLE    4'h0
`define MDGS_START_SEQ       4'h1

`endif

/* File: core/mdgs_group_table.v */
/*
  Group table: stores type, position halves, speed and next group
  for each data group, checks written values, and presents one group
  decoded at the read address.
  Assumes writes come from logic on the same clock.
*/
`timescale 1ns/1ps
`default_nettype none
`include "mdgs_map.vh"

module mdgs_group_table (
  input  wire                     clk,
  input  wire                     rst_n,
  input  wire                     ce,
  input  wire                     comm_mode,
  input  wire                     wr_en,
  input  wire [`MDGS_PNUM_W-1:0]  wr_pnum,
  input  wire [`MDGS_DATA_W-1:0]  wr_data,
  output reg                      wr_err,
  input  wire [`MDGS_GRP_W-1:0]   rd_grp,
  output wire [1:0]               rd_type,
  output wire [`MDGS_POS_W-1:0]   rd_target,
  output wire [`MDGS_SPEED_W-1:0] rd_speed,
  output wire [`MDGS_GRP_W-1:0]   rd_next
);

  reg [1:0]               type_mem  [0:`MDGS_GROUPS-1];
  reg [`MDGS_DATA_W-1:0]  lo_mem    [0:`MDGS_GROUPS-1];
  reg [`MDGS_DATA_W-1:0]  hi_mem    [0:`MDGS_GROUPS-1];
  reg [`MDGS_SPEED_W-1:0] speed_mem [0:`MDGS_GROUPS-1];
  reg [`MDGS_GRP_W-1:0]   next_mem  [0:`MDGS_GROUPS-1];
  integer i;

  // ==========================================================
  // Write decode
  // eight-entry stride
  wire [`MDGS_GRP_W-1:0] w_grp =
    wr_pnum[`MDGS_PNUM_W-1:`MDGS_PNUM_STRIDE_LSB];
  wire [2:0] w_fld = wr_pnum[`MDGS_PNUM_STRIDE_LSB-1:0];
  wire signed [`MDGS_DATA_W-1:0] w_sdata = wr_data;
  wire grp_ok = comm_mode || (w_grp < `MDGS_PARAM_GROUPS);
  reg  val_ok;

  always @* begin
    case (w_fld)
      `MDGS_FLD_TYPE:   val_ok = (wr_data[1:0] != 2'h3)
                                 && (wr_data[15:2] == 14'h0000);
      `MDGS_FLD_POS_LO,
      `MDGS_FLD_POS_HI: val_ok = (w_sdata <= `MDGS_POS_MAX)
                                 && (w_sdata >= `MDGS_POS_MIN);
      `MDGS_FLD_SPEED:  val_ok = (wr_data <= `MDGS_SPEED_MAX);
      `MDGS_FLD_NEXT:   val_ok = (wr_data < `MDGS_GROUPS);
      default:          val_ok = 1'b0;
    endcase
  end

  // Unchecked values are dropped, so the table never holds junk
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_err <= 1'b0;
      for (i = 0; i < `MDGS_GROUPS; i = i + 1) begin
        type_mem[i]  <= `MDGS_TYPE_INVALID;
        lo_mem[i]    <= 16'h0000;
        hi_mem[i]    <= 16'h0000;
        speed_mem[i] <= 13'h0000;
        next_mem[i]  <= 5'h00;
      end
    end else if (ce) begin
      wr_err <= wr_en && !(grp_ok && val_ok);
      if (wr_en && grp_ok && val_ok) begin
        case (w_fld)
          `MDGS_FLD_TYPE:   type_mem[w_grp]  <= wr_data[1:0];
          `MDGS_FLD_POS_LO: lo_mem[w_grp]    <= wr_data;
          `MDGS_FLD_POS_HI: hi_mem[w_grp]    <= wr_data;
          `MDGS_FLD_SPEED:  speed_mem[w_grp] <=
                              wr_data[`MDGS_SPEED_W-1:0];
          `MDGS_FLD_NEXT:   next_mem[w_grp]  <=
                              wr_data[`MDGS_GRP_W-1:0];
          default:          next_mem[w_grp]  <= next_mem[w_grp];
        endcase
      end
    end
  end

  // ==========================================================
  // Read decode
  wire signed [`MDGS_POS_W-1:0] lo_ext = {{16{lo_mem[rd_grp][15]}},
                                          lo_mem[rd_grp]};
  wire signed [`MDGS_POS_W-1:0] hi_ext = {{16{hi_mem[rd_grp][15]}},
                                          hi_mem[rd_grp]};
  wire signed [63:0] hi_prod = hi_ext * `MDGS_POS_HI_SCALE;

  assign rd_type   = type_mem[rd_grp];
  assign rd_target = hi_prod[`MDGS_POS_W-1:0] + lo_ext;
  assign rd_speed  = speed_mem[rd_grp];
  assign rd_next   = next_mem[rd_grp];

endmodule // mdgs_group_table

`default_nettype wire

/* File: core/mdgs_sequencer.v */
/*
  Motion data group sequencer top: servo-ready output, pin
  synchronisers, launch of single or chained data groups.
  Assumes the motion profile generator and the transition-condition
  logic sit on CLK; the host pins are asynchronous and active low.
*/
`timescale 1ns/1ps
`default_nettype none
`include "mdgs_map.vh"

// Notes on behaviour
// - Servo-ready output low means ready
// - Ready needs main power, no alarm
// - Fifteen groups by parameter, thirty-two by comms
// - Sequencing only in motion-sequence control mode
// - Start mode zero selects single group
// - Start mode one chains groups automatically
// - Single mode never starts another group
// - Chain next group after success and condition
// - Type 0 invalid, 1 absolute, 2 relative
// - Target is high*10000 plus low, bounded
// - Speed accepted from zero to 6000
// - Groups eight entries apart, five fields used
// - Permit, step, four select inputs
// - Single mode suspends motion without permit
// - Binary select, launch on step rise
module mdgs_sequencer (
  input  wire                     CLK,
  input  wire                     RESETN,
  input  wire                     CE,
  input  wire                     MAIN_POWER_ON,
  input  wire                     SERVO_ALARM,
  input  wire [3:0]               CTRL_MODE_DIGIT,
  input  wire [3:0]               START_MODE,
  input  wire                     COMM_MODE,
  input  wire                     RUN_PERMIT_N,
  input  wire                     STEP_N,
  input  wire                     GROUP_SEL0_N,
  input  wire                     GROUP_SEL1_N,
  input  wire                     GROUP_SEL2_N,
  input  wire                     GROUP_SEL3_N,
  input  wire                     MOVE_DONE,
  input  wire                     TRANS_COND_MET,
  input  wire                     CFG_WE,
  input  wire [`MDGS_PNUM_W-1:0]  CFG_PNUM,
  input  wire [`MDGS_DATA_W-1:0]  CFG_DATA,
  output reg                      CFG_ERR,
  output reg                      SERVO_READY_N,
  output reg                      MOVE_START,
  output reg                      MOVE_ABS,
  output reg  [`MDGS_POS_W-1:0]   MOVE_TARGET,
  output reg  [`MDGS_SPEED_W-1:0] MOVE_SPEED,
  output reg                      MOVE_HOLD,
  output reg  [`MDGS_GRP_W-1:0]   ACTIVE_GROUP,
  output reg                      BUSY
);

  localparam ST_IDLE = 2'b00;
  localparam ST_RUN  = 2'b01;
  localparam ST_WAIT = 2'b10;

  // ==========================================================
  // Reset release
  reg rst_meta;
  reg rst_n;

  always @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      rst_meta <= 1'b0;
      rst_n    <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_n    <= rst_meta;
    end
  end

  // ==========================================================
  // Pin synchronisers
  // permit, step, four selects
  wire [5:0] pin_raw = {STEP_N, RUN_PERMIT_N, GROUP_SEL3_N,
                        GROUP_SEL2_N, GROUP_SEL1_N, GROUP_SEL0_N};
  wire [5:0] pin_sync;

  genvar g;
  generate
    for (g = 0; g < 6; g = g + 1) begin : g_sync
      reg meta;
      reg sync;
      // Idle pin level is high (off), so reset to off
      always @(posedge CLK or negedge rst_n) begin
        if (!rst_n) begin
          meta <= 1'b1;
          sync <= 1'b1;
        end else if (CE) begin
          meta <= pin_raw[g];
          sync <= meta;
        end
      end
      assign pin_sync[g] = sync;
    end
  endgenerate

  reg step_prev;
  wire [`MDGS_GRP_W-1:0] sel_grp = {1'b0, ~pin_sync[3:0]};
  wire permit_on = ~pin_sync[4];
  wire step_on   = ~pin_sync[5];
  wire step_rise = step_on && !step_prev;

  // ==========================================================
  // Mode decode
  // motion-sequence mode only
  wire seq_mode  = (CTRL_MODE_DIGIT == `MDGS_CTRL_MODE_SEQ);
  wire mode_single = (START_MODE == `MDGS_START_SINGLE);
  wire mode_chain  = (START_MODE == `MDGS_START_SEQ);

  // ==========================================================
  // Group table
  reg  [1:0]               state;
  reg  [`MDGS_GRP_W-1:0]   chain_grp;
  wire [`MDGS_GRP_W-1:0]   rd_grp = (state == ST_IDLE) ? sel_grp
                                                       : chain_grp;
  wire [1:0]               rd_type;
  wire [`MDGS_POS_W-1:0]   rd_target;
  wire [`MDGS_SPEED_W-1:0] rd_speed;
  wire [`MDGS_GRP_W-1:0]   rd_next;
  wire                     tbl_err;

  mdgs_group_table u_table (
    .clk       (CLK),
    .rst_n     (rst_n),
    .ce        (CE),
    .comm_mode (COMM_MODE),
    .wr_en     (CFG_WE),
    .wr_pnum   (CFG_PNUM),
    .wr_data   (CFG_DATA),
    .wr_err    (tbl_err),
    .rd_grp    (rd_grp),
    .rd_type   (rd_type),
    .rd_target (rd_target),
    .rd_speed  (rd_speed),
    .rd_next   (rd_next)
  );

  wire grp_in_range = COMM_MODE || (rd_grp < `MDGS_PARAM_GROUPS);
  wire grp_valid = grp_in_range && (rd_type != `MDGS_TYPE_INVALID);

  // ==========================================================
  // Sequencer
  reg [1:0] next_state;
  reg       launch;

  always @* begin
    next_state = state;
    launch     = 1'b0;
    case (state)
      ST_IDLE: begin
        if (seq_mode && (mode_single || mode_chain) && permit_on
            && step_rise && grp_valid) begin
          launch     = 1'b1;
          next_state = ST_RUN;
        end
      end
      ST_RUN: begin
        if (!seq_mode) begin
          next_state = ST_IDLE;
        end else if (MOVE_DONE && !MOVE_START) begin
          next_state = mode_chain ? ST_WAIT : ST_IDLE;
        end
      end
      ST_WAIT: begin
        if (!seq_mode || !mode_chain) begin
          next_state = ST_IDLE;
        end else if (TRANS_COND_MET) begin
          if (grp_valid) begin
            launch     = 1'b1;
            next_state = ST_RUN;
          end else begin
            next_state = ST_IDLE;
          end
        end
      end
      default: next_state = ST_IDLE;
    endcase
  end

  always @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      state         <= ST_IDLE;
      step_prev     <= 1'b0;
      chain_grp     <= 5'h00;
      CFG_ERR       <= 1'b0;
      SERVO_READY_N <= 1'b1;
      MOVE_START    <= 1'b0;
      MOVE_ABS      <= 1'b0;
      MOVE_TARGET   <= 32'h0000_0000;
      MOVE_SPEED    <= 13'h0000;
      MOVE_HOLD     <= 1'b0;
      ACTIVE_GROUP  <= 5'h00;
      BUSY          <= 1'b0;
    end else if (CE) begin
      state      <= next_state;
      step_prev  <= step_on;
      CFG_ERR    <= tbl_err;
      MOVE_START <= launch;
      BUSY       <= (next_state != ST_IDLE);
      SERVO_READY_N <= ~(MAIN_POWER_ON && !SERVO_ALARM);
      MOVE_HOLD <= (next_state == ST_RUN) && mode_single && !permit_on;
      if (launch) begin
        ACTIVE_GROUP <= rd_grp;
        chain_grp    <= rd_next;
        MOVE_ABS     <= (rd_type == `MDGS_TYPE_ABS);
        MOVE_TARGET  <= rd_target;
        MOVE_SPEED   <= rd_speed;
      end
    end
  end

endmodule // mdgs_sequencer

`default_nettype wire

/* File: sim/mdgs_props.sv */
/* Assertions on the sequencer top ports, bound to every instance.
   Assumes CE stays high while the checker watches. */
`timescale 1ns/1ps
`default_nettype none
`include "mdgs_map.vh"
// ============================================================
// Port checker
module mdgs_props (
  input wire logic                     CLK,
  input wire logic                     RESETN,
  input wire logic                     MAIN_POWER_ON,
  input wire logic                     SERVO_ALARM,
  input wire logic [3:0]               CTRL_MODE_DIGIT,
  input wire logic [3:0]               START_MODE,
  input wire logic                     RUN_PERMIT_N,
  input wire logic                     MOVE_DONE,
  input wire logic                     CFG_WE,
  input wire logic [`MDGS_PNUM_W-1:0]  CFG_PNUM,
  input wire logic                     CFG_ERR,
  input wire logic                     SERVO_READY_N,
  input wire logic                     MOVE_START,
  input wire logic [`MDGS_POS_W-1:0]   MOVE_TARGET,
  input wire logic [`MDGS_SPEED_W-1:0] MOVE_SPEED,
  input wire logic                     MOVE_HOLD,
  input wire logic [`MDGS_GRP_W-1:0]   ACTIVE_GROUP,
  input wire logic                     BUSY
);
  // Outputs stay in reset until the two-stage release is over
  logic [1:0] up;
  always @(posedge CLK or negedge RESETN) begin
    if (!RESETN) up <= 2'h0;
    else if (up != 2'h3) up <= up + 2'h1;
  end
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RESETN || up != 2'h3);
  property p_ready;
    SERVO_READY_N == !($past(MAIN_POWER_ON) && !$past(SERVO_ALARM));
  endproperty
  a_ready: assert property (p_ready)
    else $error("servo ready level wrong");
  property p_pulse;
    MOVE_START |=> !MOVE_START;
  endproperty
  a_pulse: assert property (p_pulse)
    else $error("start longer than one cycle");
  property p_speed;
    MOVE_START |-> BUSY && MOVE_SPEED <= `MDGS_SPEED_MAX;
  endproperty
  a_speed: assert property (p_speed)
    else $error("start without busy or speed too high");
  property p_mode;
    MOVE_START |-> $past(CTRL_MODE_DIGIT) == `MDGS_CTRL_MODE_SEQ
      && $past(START_MODE) <= `MDGS_START_SEQ;
  endproperty
  a_mode: assert property (p_mode)
    else $error("start outside sequence mode");
  property p_single;
    START_MODE == `MDGS_START_SINGLE && BUSY && MOVE_DONE && !MOVE_START
      |=> !BUSY && !MOVE_START;
  endproperty
  a_single: assert property (p_single)
    else $error("single mode did not stop");
  property p_hold;
    $rose(MOVE_HOLD) |-> $past(RUN_PERMIT_N, 3)
      && $past(START_MODE) == `MDGS_START_SINGLE;
  endproperty
  a_hold: assert property (p_hold)
    else $error("hold without permit off");
  property p_keep;
    !MOVE_START |-> $stable(MOVE_TARGET) && $stable(ACTIVE_GROUP);
  endproperty
  a_keep: assert property (p_keep)
    else $error("move data changed without start");
  property p_cfg;
    CFG_WE && CFG_PNUM[2:0] >= 3'h4 && CFG_PNUM[2:0] <= 3'h6 |-> ##2 CFG_ERR;
  endproperty
  a_cfg: assert property (p_cfg)
    else $error("unused entry write not rejected");
endmodule // mdgs_props

bind mdgs_sequencer mdgs_props u_mdgs_props (
  .CLK(CLK), .RESETN(RESETN), .MAIN_POWER_ON(MAIN_POWER_ON),
  .SERVO_ALARM(SERVO_ALARM), .CTRL_MODE_DIGIT(CTRL_MODE_DIGIT),
  .START_MODE(START_MODE), .RUN_PERMIT_N(RUN_PERMIT_N),
  .MOVE_DONE(MOVE_DONE), .CFG_WE(CFG_WE), .CFG_PNUM(CFG_PNUM),
  .CFG_ERR(CFG_ERR), .SERVO_READY_N(SERVO_READY_N),
  .MOVE_START(MOVE_START), .MOVE_TARGET(MOVE_TARGET),
  .MOVE_SPEED(MOVE_SPEED), .MOVE_HOLD(MOVE_HOLD),
  .ACTIVE_GROUP(ACTIVE_GROUP), .BUSY(BUSY));
`default_nettype wire

/* File: sim/mdgs_host_model.sv */
/* Host controller model driving the active-low permit, step and
   select pins. Assumes requests change on the falling clock edge. */
`timescale 1ns/1ps
`default_nettype none
// ============================================================
// Host pins
module mdgs_host_model (
  input  wire logic       clk,
  input  wire logic       permit,
  input  wire logic       go,
  input  wire logic [3:0] grp,
  output var  logic       permit_n,
  output var  logic       step_n,
  output var  logic [3:0] sel_n
);
  logic go_d;
  initial begin
    permit_n = 1'b1;
    step_n = 1'b1;
    sel_n = 4'hF;
    go_d = 1'b0;
  end
  // host times steps
  // Step lags the select a cycle so the group is settled first
  always @(negedge clk) begin
    permit_n <= !permit;
    sel_n    <= ~grp;
    go_d     <= go;
    step_n   <= !go_d;
  end
endmodule // mdgs_host_model
`default_nettype wire

/* File: sim/mdgs_sequencer_tb_top.sv */
/* Self-checking bench: table writes, single and chained launches.
   Assumes CE held high; host pins come from the host model. */
`timescale 1ns/1ps
`default_nettype none
module mdgs_sequencer_tb_top;
  logic clk = 1'b0, rst_n = 1'b0, pwr = 1'b0, alm = 1'b0, comm = 1'b0;
  logic permit = 1'b0, go = 1'b0, done = 1'b0, cond = 1'b0, we = 1'b0;
  logic [3:0] mode = 4'hC, smode = 4'h0, grp = 4'h0;
  logic [7:0] pnum = 8'h00;
  logic [15:0] data = 16'h0000;
  wire permit_n, step_n, err, rdy_n, start, abs_m, hold, busy;
  wire [3:0] sel_n;
  wire [31:0] tgt;
  wire [12:0] spd;
  wire [4:0] agrp;
  integer miscompares = 0, checked = 0, cyc = 0, starts = 0, i, n;
  logic [31:0] s_tgt;
  logic [4:0] s_grp;
  logic s_abs;
  logic [12:0] s_spd;
  always #12.5 clk = ~clk;
  mdgs_host_model u_mdgs_host_model (.clk(clk), .permit(permit), .go(go),
    .grp(grp), .permit_n(permit_n), .step_n(step_n), .sel_n(sel_n));
  mdgs_sequencer u_mdgs_sequencer (.CLK(clk), .RESETN(rst_n), .CE(1'b1),
    .MAIN_POWER_ON(pwr), .SERVO_ALARM(alm), .CTRL_MODE_DIGIT(mode),
    .START_MODE(smode), .COMM_MODE(comm), .RUN_PERMIT_N(permit_n),
    .STEP_N(step_n), .GROUP_SEL0_N(sel_n[0]), .GROUP_SEL1_N(sel_n[1]),
    .GROUP_SEL2_N(sel_n[2]), .GROUP_SEL3_N(sel_n[3]), .MOVE_DONE(done),
    .TRANS_COND_MET(cond), .CFG_WE(we), .CFG_PNUM(pnum), .CFG_DATA(data),
    .CFG_ERR(err), .SERVO_READY_N(rdy_n), .MOVE_START(start),
    .MOVE_ABS(abs_m), .MOVE_TARGET(tgt), .MOVE_SPEED(spd),
    .MOVE_HOLD(hold), .ACTIVE_GROUP(agrp), .BUSY(busy));
  // Launch monitor samples away from the rising edge
  always @(negedge clk) begin
    if (start === 1'b1) begin
      starts = starts + 1;
      s_tgt = tgt;
      s_grp = agrp;
      s_abs = abs_m;
      s_spd = spd;
    end
    cyc = cyc + 1;
    if (cyc == 5000) begin
      miscompares = miscompares + 1;
      final_report;
    end
  end
  task chk(input logic [63:0] seen, input logic [63:0] exp);
    checked = checked + 1;
    if (seen !== exp) begin
      miscompares = miscompares + 1;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task final_report;
    $display("checked %0d miscompares %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task wr(input logic [7:0] p, input logic [15:0] d, input logic e);
    @(negedge clk);
    we <= 1'b1;
    pnum <= p;
    data <= d;
    @(negedge clk);
    we <= 1'b0;
    @(posedge clk);
    #1 chk(err, e);
  endtask
  task launch(input logic [3:0] g, input integer exp_n);
    integer n0;
    n0 = starts;
    @(negedge clk);
    grp <= g;
    go <= 1'b1;
    @(negedge clk);
    go <= 1'b0;
    repeat (8) @(negedge clk);
    chk(starts - n0, exp_n);
  endtask
  task finish_move;
    @(negedge clk) done <= 1'b1;
    @(negedge clk) done <= 1'b0;
    @(negedge clk);
  endtask
  initial begin
    repeat (4) @(negedge clk);
    chk(rdy_n, 1'b1);
    rst_n <= 1'b1;
    repeat (4) @(negedge clk);
    for (i = 0; i < 4; i = i + 1) begin
      pwr <= i[0];
      alm <= i[1];
      repeat (2) @(negedge clk);
      chk(rdy_n, i != 1);
    end
    pwr <= 1'b1;
    alm <= 1'b0;
    $display("ready test end");
    wr(8'h08, 16'h0001, 1'b0);
    wr(8'h09, 16'hFFFB, 1'b0);
    wr(8'h0A, 16'h0003, 1'b0);
    wr(8'h0B, 16'h1770, 1'b0);
    wr(8'h0F, 16'h0002, 1'b0);
    wr(8'h10, 16'h0002, 1'b0);
    wr(8'h11, 16'h270F, 1'b0);
    wr(8'h12, 16'hFFFF, 1'b0);
    wr(8'h1D, 16'h0000, 1'b1);
    wr(8'h18, 16'h0003, 1'b1);
    wr(8'h19, 16'h2710, 1'b1);
    wr(8'h1A, 16'hD8F0, 1'b1);
    wr(8'h1B, 16'h1771, 1'b1);
    wr(8'h78, 16'h0001, 1'b1);
    comm <= 1'b1;
    wr(8'h78, 16'h0001, 1'b0);
    comm <= 1'b0;
    $display("table test end");
    permit <= 1'b1;
    launch(4'h1, 1);
    chk(s_tgt, 32'h0000_752B);
    chk({s_abs, s_grp}, 6'h21);
    chk(s_spd, 13'h1770);
    chk(busy, 1'b1);
    finish_move;
    chk(busy, 1'b0);
    launch(4'h0, 0);
    launch(4'h2, 1);
    chk({s_abs, s_grp, s_tgt}, 38'h02_FFFF_FFFF);
    permit <= 1'b0;
    repeat (5) @(negedge clk);
    chk(hold, 1'b1);
    permit <= 1'b1;
    repeat (5) @(negedge clk);
    chk(hold, 1'b0);
    finish_move;
    permit <= 1'b0;
    launch(4'h1, 0);
    permit <= 1'b1;
    mode <= 4'h3;
    launch(4'h1, 0);
    mode <= 4'hC;
    smode <= 4'h2;
    launch(4'h1, 0);
    smode <= 4'h0;
    launch(4'hF, 0);
    comm <= 1'b1;
    launch(4'hF, 1);
    finish_move;
    comm <= 1'b0;
    $display("single test end");
    smode <= 4'h1;
    launch(4'h1, 1);
    finish_move;
    chk(busy, 1'b1);
    n = starts;
    cond <= 1'b1;
    repeat (4) @(negedge clk);
    cond <= 1'b0;
    chk(starts - n, 1);
    chk(s_grp, 5'h02);
    finish_move;
    cond <= 1'b1;
    repeat (4) @(negedge clk);
    cond <= 1'b0;
    chk(busy, 1'b0);
    $display("chain test end");
    final_report;
  end
endmodule // mdgs_sequencer_tb_top
`default_nettype wire
